// File: pkg/status_summary_pkg.sv
// constants for the fault summary status block
package status_summary_pkg;

    // command codes answered by this block
    localparam logic [7:0] CMD_CRITICAL_SUMMARY = 8'h78;
    localparam logic [7:0] CMD_FAULT_WARN_SUMMARY = 8'h79;

    // answer lengths in bytes
    localparam logic [1:0] LEN_NONE = 2'h0;
    localparam logic [1:0] LEN_BYTE = 2'h1;
    localparam logic [1:0] LEN_WORD = 2'h2;

    // critical summary bit positions
    localparam int CRIT_OFF_BIT = 6;
    localparam int CRIT_OV_FAULT_BIT = 5;
    localparam int CRIT_OC_FAULT_BIT = 4;
    localparam int CRIT_TEMP_BIT = 2;
    localparam int CRIT_COMMS_BIT = 1;
    localparam int CRIT_MISC_BIT = 0;

    // high byte bit positions
    localparam int HI_VOUT_BIT = 7;
    localparam int HI_IOUT_BIT = 6;
    localparam int HI_INPUT_BIT = 5;
    localparam int HI_VENDOR_BIT = 4;
    localparam int HI_PNG_BIT = 3;

    // output voltage status source bits
    localparam int VOUT_OV_FAULT_BIT = 7;
    localparam int VOUT_OV_WARN_BIT = 6;
    localparam int VOUT_UV_WARN_BIT = 5;
    localparam int VOUT_UV_FAULT_BIT = 4;
    localparam int VOUT_LIMIT_BIT = 3;
    localparam int VOUT_TONMAX_BIT = 2;

    // output current status source bits
    localparam int IOUT_OC_FAULT_BIT = 7;
    localparam int IOUT_OC_WARN_BIT = 5;

    // temperature and input status source bits
    localparam int TEMP_FAULT_BIT = 7;
    localparam int TEMP_WARN_BIT = 6;
    localparam int INPUT_LOW_VIN_BIT = 3;

    // implemented bits; all others read zero
    localparam logic [7:0] VOUT_USED_MASK = 8'hfc;
    localparam logic [7:0] IOUT_USED_MASK = 8'ha0;
    localparam logic [7:0] TEMP_USED_MASK = 8'hc0;
    localparam logic [7:0] CRIT_USED_MASK = 8'h77;
    localparam logic [7:0] HI_USED_MASK = 8'hf8;

    // values after reset
    localparam logic [7:0] CRIT_RESET = 8'h01;
    localparam logic [7:0] HI_RESET = 8'h20;
    localparam logic PNG_MASK_RESET = 1'b1;
    localparam logic LOW_VIN_RESET = 1'b1;

endpackage

// File: verilog/low_vin_tracker.sv
// input undervoltage flag with unlatched power-up phase
`timescale 1ns/1ps

module low_vin_tracker (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // live input voltage comparisons
    input  wire logic vin_above_on,
    input  wire logic vin_below_off,
    // host clear of the latched flag
    input  wire logic clear,
    // flag and its alert request
    output logic      flag,
    output logic      alert
);

    logic armed_q;
    logic armed_d;
    logic flag_q;
    logic flag_d;
    logic alert_q;
    logic alert_d;

    always_comb begin
        armed_d = armed_q;
        flag_d  = flag_q;
        if (!armed_q) begin
            // power-up phase: unlatched, no alert, ends at first turn-on
            armed_d = vin_above_on;
            flag_d  = !vin_above_on;
        end else begin
            // set wins over a clear in the same cycle
            flag_d = vin_below_off | (flag_q & !clear);
        end
        alert_d = flag_d & armed_d;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            armed_q <= 1'b0;
            flag_q  <= status_summary_pkg::LOW_VIN_RESET;
            alert_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            flag_q  <= flag_d;
            alert_q <= alert_d;
        end
    end

    assign flag  = flag_q;
    assign alert = alert_q;

endmodule

// File: verilog/status_summary.sv
// fault summary status: critical byte and fault/warning word
//
// Contract
// - read of code 78h answers one read-only critical summary byte.
// - bit 6 set whenever the converter is not enabled.
// - bit 5 mirrors overvoltage fault, output voltage status bit 7.
// - overvoltage summary bit reads 0 for a loop slave.
// - bit 4 mirrors overcurrent fault, output current status bit 7.
// - writes never clear summaries; only clearing the sources does.
// - bit 2 set while any temperature fault or warning is set.
// - bit 1 set while any communication, memory, logic fault set.
// - bit 0 set by other output voltage/current conditions, input undervoltage, bandgap overtemperature or vendor fault.
// - after reset bit 0 reads 1 since input undervoltage starts set.
// - read of 79h answers two bytes; low byte equals critical byte.
// - high bit 7 is OR of all output voltage faults and warnings, 0 for a loop slave.
// - high bit 6 is OR of overcurrent fault and warning.
// - high bit 5 set while any input status flag is present.
// - high bit 4 set on bandgap overtemperature or vendor fault.
// - high bit 3 is unlatched live power-not-good.
// - power-not-good alert mask defaults to 1.
// - unmasked power-not-good alerts only after first power good.
// - input undervoltage starts set, unlatched, later drops latched.
`timescale 1ns/1ps

module status_summary (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,

    // command port from the bus engine
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,

    // answer to the bus engine
    output logic             resp_valid,
    output logic             resp_hit,
    output logic [1:0]       resp_bytes,
    output logic [15:0]      resp_data,

    // detailed status sources
    input  wire logic [7:0]  output_voltage_status_reg,
    input  wire logic [7:0]  output_current_status_reg,
    input  wire logic [7:0]  input_status_other,
    input  wire logic [7:0]  temperature_status_reg,
    input  wire logic [7:0]  comms_fault_status_reg,
    input  wire logic        bandgap_overtemp_flag,
    input  wire logic        vendor_fault_condition,

    // converter state
    input  wire logic        converter_enabled,
    input  wire logic        loop_slave,
    input  wire logic        power_good,

    // input voltage monitor
    input  wire logic        vin_above_on,
    input  wire logic        vin_below_off,
    input  wire logic        low_vin_clear,

    // power-not-good alert mask configuration
    input  wire logic        png_mask_write,
    input  wire logic        png_mask_value,

    // summaries and alert requests
    output logic [7:0]       critical_fault_summary,
    output logic [15:0]      fault_warning_summary,
    output logic             low_vin_flag,
    output logic             low_vin_alert,
    output logic             png_alert
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // true for either summary command
    function automatic logic is_summary_code(input logic [7:0] code);
        is_summary_code = (code == status_summary_pkg::CMD_CRITICAL_SUMMARY)
                       || (code == status_summary_pkg::CMD_FAULT_WARN_SUMMARY);
    endfunction

    // answer length of a summary read
    function automatic logic [1:0] read_length(input logic [7:0] code);
        if (code == status_summary_pkg::CMD_FAULT_WARN_SUMMARY) begin
            read_length = status_summary_pkg::LEN_WORD;
        end else begin
            read_length = status_summary_pkg::LEN_BYTE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input undervoltage tracking

    logic lv_flag;
    logic lv_alert;

    low_vin_tracker low_vin_tracker_inst (
        .clock         (clock),
        .srst          (srst),
        .vin_above_on  (vin_above_on),
        .vin_below_off (vin_below_off),
        .clear        (low_vin_clear),
        .flag         (lv_flag),
        .alert        (lv_alert)
    );

    ////////////////////////////////////////////////////////////////////
    // source gathering

    logic [7:0] vout_src;
    logic [7:0] iout_src;
    logic [7:0] temp_src;
    logic [7:0] input_src;
    logic       vout_any;
    logic       iout_any;
    logic       temp_any;
    logic       input_any;
    logic       comms_any;
    logic       vendor_any;
    logic       misc_any;
    logic       png_live;

    always_comb begin
        // a loop slave never reports output voltage conditions
        if (loop_slave) begin
            vout_src = 8'h00;
        end else begin
            vout_src = output_voltage_status_reg
                     & status_summary_pkg::VOUT_USED_MASK;
        end
        iout_src = output_current_status_reg
                 & status_summary_pkg::IOUT_USED_MASK;
        temp_src = temperature_status_reg
                 & status_summary_pkg::TEMP_USED_MASK;

        // the undervoltage bit is owned by the local tracker
        input_src = input_status_other;
        input_src[status_summary_pkg::INPUT_LOW_VIN_BIT] = lv_flag;

        vout_any   = |vout_src;
        iout_any   = |iout_src;
        temp_any   = |temp_src;
        input_any  = |input_src;
        comms_any  = |comms_fault_status_reg;
        vendor_any = bandgap_overtemp_flag | vendor_fault_condition;

        // output, undervoltage and vendor conditions not covered by bits 1..7 of the critical byte
        misc_any = vout_src[status_summary_pkg::VOUT_UV_FAULT_BIT]
                 | vout_src[status_summary_pkg::VOUT_OV_WARN_BIT]
                 | vout_src[status_summary_pkg::VOUT_UV_WARN_BIT]
                 | vout_src[status_summary_pkg::VOUT_LIMIT_BIT]
                 | vout_src[status_summary_pkg::VOUT_TONMAX_BIT]
                 | iout_src[status_summary_pkg::IOUT_OC_WARN_BIT]
                 | lv_flag
                 | vendor_any;

        // unlatched: follows the live power good level
        png_live = !power_good;
    end

    ////////////////////////////////////////////////////////////////////
    // summary registers

    logic [7:0] crit_q;
    logic [7:0] crit_d;
    logic [7:0] hi_q;
    logic [7:0] hi_d;

    // no write path reaches these; they only follow their sources
    always_comb begin
        crit_d = 8'h00;
        crit_d[status_summary_pkg::CRIT_OFF_BIT] = !converter_enabled;
        crit_d[status_summary_pkg::CRIT_OV_FAULT_BIT] =
            vout_src[status_summary_pkg::VOUT_OV_FAULT_BIT];
        crit_d[status_summary_pkg::CRIT_OC_FAULT_BIT] =
            iout_src[status_summary_pkg::IOUT_OC_FAULT_BIT];
        crit_d[status_summary_pkg::CRIT_TEMP_BIT]  = temp_any;
        crit_d[status_summary_pkg::CRIT_COMMS_BIT] = comms_any;
        crit_d[status_summary_pkg::CRIT_MISC_BIT] = misc_any;
        crit_d = crit_d & status_summary_pkg::CRIT_USED_MASK;

        hi_d = 8'h00;
        hi_d[status_summary_pkg::HI_VOUT_BIT]   = vout_any;
        hi_d[status_summary_pkg::HI_IOUT_BIT]   = iout_any;
        hi_d[status_summary_pkg::HI_INPUT_BIT]  = input_any;
        hi_d[status_summary_pkg::HI_VENDOR_BIT] = vendor_any;
        hi_d[status_summary_pkg::HI_PNG_BIT]    = png_live;
        hi_d = hi_d & status_summary_pkg::HI_USED_MASK;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            crit_q <= status_summary_pkg::CRIT_RESET;
            hi_q   <= status_summary_pkg::HI_RESET;
        end else begin
            crit_q <= crit_d;
            hi_q   <= hi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-not-good alert gating

    logic png_mask_q;
    logic png_mask_d;
    logic pg_seen_q;
    logic pg_seen_d;
    logic png_alert_q;
    logic png_alert_d;

    always_comb begin
        png_mask_d = png_mask_q;
        if (png_mask_write) begin
            png_mask_d = png_mask_value;
        end
        // avoids holding the alert line while never commanded on
        pg_seen_d = pg_seen_q | power_good;
        png_alert_d = png_live & !png_mask_q & pg_seen_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            png_mask_q  <= status_summary_pkg::PNG_MASK_RESET;
            pg_seen_q   <= 1'b0;
            png_alert_q <= 1'b0;
        end else begin
            png_mask_q  <= png_mask_d;
            pg_seen_q   <= pg_seen_d;
            png_alert_q <= png_alert_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command answers

    logic        resp_valid_q;
    logic        resp_valid_d;
    logic        resp_hit_q;
    logic        resp_hit_d;
    logic [1:0]  resp_bytes_q;
    logic [1:0]  resp_bytes_d;
    logic [15:0] resp_data_q;
    logic [15:0] resp_data_d;

    always_comb begin
        resp_valid_d = cmd_valid;
        resp_hit_d   = 1'b0;
        resp_bytes_d = status_summary_pkg::LEN_NONE;
        resp_data_d  = 16'h0000;
        if (cmd_valid && is_summary_code(cmd_code)) begin
            resp_hit_d = 1'b1;
            if (!cmd_write) begin
                resp_bytes_d = read_length(cmd_code);
                if (cmd_code == status_summary_pkg::CMD_FAULT_WARN_SUMMARY)
                begin
                    // low byte is the critical summary itself
                    resp_data_d = {hi_q, crit_q};
                end else begin
                    resp_data_d = {8'h00, crit_q};
                end
            end
            // a write is taken but stores nothing
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            resp_valid_q <= 1'b0;
            resp_hit_q   <= 1'b0;
            resp_bytes_q <= status_summary_pkg::LEN_NONE;
            resp_data_q  <= 16'h0000;
        end else begin
            resp_valid_q <= resp_valid_d;
            resp_hit_q   <= resp_hit_d;
            resp_bytes_q <= resp_bytes_d;
            resp_data_q  <= resp_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign resp_valid             = resp_valid_q;
    assign resp_hit               = resp_hit_q;
    assign resp_bytes             = resp_bytes_q;
    assign resp_data              = resp_data_q;
    assign critical_fault_summary = crit_q;
    assign fault_warning_summary  = {hi_q, crit_q};
    assign low_vin_flag           = lv_flag;
    assign low_vin_alert          = lv_alert;
    assign png_alert              = png_alert_q;

endmodule

// File: tb/status_summary_checker.sv
// assertions on the ports of the fault summary block
`timescale 1ns/1ps

module status_summary_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // command and answer
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic        resp_valid,
    input wire logic        resp_hit,
    input wire logic [1:0]  resp_bytes,
    input wire logic [15:0] resp_data,
    // sources and state
    input wire logic [7:0]  output_voltage_status_reg,
    input wire logic [7:0]  output_current_status_reg,
    input wire logic [7:0]  temperature_status_reg,
    input wire logic [7:0]  comms_fault_status_reg,
    input wire logic        bandgap_overtemp_flag,
    input wire logic        vendor_fault_condition,
    input wire logic        converter_enabled,
    input wire logic        loop_slave,
    input wire logic        power_good,
    // summaries
    input wire logic [7:0]  critical_fault_summary,
    input wire logic [15:0] fault_warning_summary,
    input wire logic        png_alert
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    logic [7:0]  vs;
    logic [7:0]  io;
    logic [7:0]  cs;
    logic [15:0] ws;
    logic        seen_q;
    logic        seen_d;
    assign vs = output_voltage_status_reg;
    assign io = output_current_status_reg;
    assign cs = critical_fault_summary;
    assign ws = fault_warning_summary;

    // power good seen once since reset
    always_comb seen_d = seen_q | power_good;
    always_ff @(posedge clock) begin
        if (srst) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
        end
    end

    sequence s_rd(c);
        cmd_valid && !cmd_write && cmd_code == c;
    endsequence
    // summaries lag sources by one edge, so skip the edge after reset
    sequence s_live;
        !$past(srst);
    endsequence

    chk_resp_strobe: assert property (
        s_live |-> resp_valid == $past(cmd_valid))
        else $error("answer strobe not one edge after request");
    chk_crit_read: assert property (
        s_rd(8'h78) |=> resp_hit && resp_bytes == 2'h1
        && resp_data == {8'h00, $past(cs)})
        else $error("critical summary read wrong");
    chk_word_read: assert property (
        s_rd(8'h79) |=> resp_hit && resp_bytes == 2'h2
        && resp_data == $past(ws))
        else $error("summary word read wrong");
    chk_word_low: assert property (ws[7:0] == cs)
        else $error("word low byte differs from critical byte");
    chk_write_ignored: assert property (
        cmd_valid && cmd_write |=>
        resp_bytes == 2'h0 && resp_data == 16'h0000)
        else $error("write answered with data");
    chk_off_flag: assert property (
        s_live |-> cs[6] == !$past(converter_enabled))
        else $error("off flag wrong");
    chk_ov_mirror: assert property (
        s_live |-> cs[5] == $past(vs[7] & !loop_slave))
        else $error("overvoltage mirror wrong");
    chk_oc_mirror: assert property (
        s_live |-> cs[4] == $past(io[7]))
        else $error("overcurrent mirror wrong");
    chk_temp_bit: assert property (
        s_live |-> cs[2] == $past(|temperature_status_reg[7:6]))
        else $error("temperature bit wrong");
    chk_comms_bit: assert property (
        s_live |-> cs[1] == $past(|comms_fault_status_reg))
        else $error("comms bit wrong");
    chk_hi_vout: assert property (
        s_live |-> ws[15] == $past(|vs[7:2] & !loop_slave))
        else $error("output voltage summary wrong");
    chk_hi_iout: assert property (
        s_live |-> ws[14] == $past(io[7] | io[5]))
        else $error("output current summary wrong");
    chk_hi_vendor: assert property (
        s_live |-> ws[12]
            == $past(bandgap_overtemp_flag | vendor_fault_condition))
        else $error("vendor summary wrong");
    chk_hi_png: assert property (
        s_live |-> ws[11] == !$past(power_good))
        else $error("power not good bit wrong");
    chk_unused_zero: assert property (
        cs[7] == 1'b0 && cs[3] == 1'b0 && ws[10:8] == 3'h0)
        else $error("unused summary bit set");
    chk_png_hold: assert property (
        !seen_q |-> !png_alert)
        else $error("power not good alert before first power good");
endmodule

bind status_summary status_summary_checker status_summary_checker_inst (
    .clock, .srst, .cmd_valid, .cmd_write, .cmd_code, .resp_valid,
    .resp_hit, .resp_bytes, .resp_data, .output_voltage_status_reg,
    .output_current_status_reg, .temperature_status_reg,
    .comms_fault_status_reg, .bandgap_overtemp_flag,
    .vendor_fault_condition, .converter_enabled, .loop_slave,
    .power_good, .critical_fault_summary, .fault_warning_summary,
    .png_alert);

// File: tb/status_host_model.sv
// host side model issuing status commands
`timescale 1ns/1ps

module status_host_model (
    // clock
    input  wire logic        clock,
    // request
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    // answer
    input  wire logic        resp_valid,
    input  wire logic        resp_hit,
    input  wire logic [1:0]  resp_bytes,
    input  wire logic [15:0] resp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
    end

    // idle qualifiers are inverted so a late sample cannot match
    task automatic xfer(input logic wr, input logic [7:0] code,
        output logic ok, output logic hit, output logic [1:0] n,
        output logic [15:0] d);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        @(negedge clock);
        ok = resp_valid;
        hit = resp_hit;
        n = resp_bytes;
        d = resp_data;
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_code  = ~code;
    endtask
endmodule

// File: tb/status_summary_bench.sv
// self-checking bench for the fault summary block
`timescale 1ns/1ps

module status_summary_bench;
    logic        clock;
    logic        srst;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_code;
    logic        resp_valid;
    logic        resp_hit;
    logic [1:0]  resp_bytes;
    logic [15:0] resp_data;
    logic [7:0]  vs;
    logic [7:0]  io;
    logic [7:0]  ts;
    logic [7:0]  comms;
    logic [7:0]  ins;
    logic        bg;
    logic        vend;
    logic        en;
    logic        slave;
    logic        pg;
    logic        von;
    logic        voff;
    logic        vclr;
    logic        mw;
    logic        mv;
    logic [7:0]  crit;
    logic [15:0] word;
    logic        lv_flag;
    logic        lv_alert;
    logic        png_alert;
    int          err_count;
    int          checked;

    status_summary status_summary_inst (
        .clock, .srst, .cmd_valid, .cmd_write, .cmd_code, .resp_valid,
        .resp_hit, .resp_bytes, .resp_data,
        .output_voltage_status_reg(vs), .output_current_status_reg(io),
        .input_status_other(ins), .temperature_status_reg(ts),
        .comms_fault_status_reg(comms), .bandgap_overtemp_flag(bg),
        .vendor_fault_condition(vend), .converter_enabled(en),
        .loop_slave(slave), .power_good(pg), .vin_above_on(von),
        .vin_below_off(voff), .low_vin_clear(vclr),
        .png_mask_write(mw), .png_mask_value(mv),
        .critical_fault_summary(crit), .fault_warning_summary(word),
        .low_vin_flag(lv_flag), .low_vin_alert(lv_alert), .png_alert);

    status_host_model status_host_model_inst (
        .clock, .cmd_valid, .cmd_write, .cmd_code, .resp_valid,
        .resp_hit, .resp_bytes, .resp_data);

    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // only 78h and 79h are hits, reads or writes
    task automatic acc(input logic wr, input logic [7:0] code,
        input logic [1:0] len, input logic [15:0] dat);
        logic        ok;
        logic        hit;
        logic [1:0]  n;
        logic [15:0] d;
        status_host_model_inst.xfer(wr, code, ok, hit, n, d);
        cmp(16'h0001, {15'h0, ok});
        cmp({15'h0, code[7:1] == 7'h3c}, {15'h0, hit});
        cmp({14'h0, len}, {14'h0, n});
        cmp(dat, d);
    endtask

    // f holds bandgap, vendor, enable, slave, power good
    task automatic src(input logic [31:0] s, input logic [4:0] f,
        input logic [15:0] w);
        {vs, io, ts, comms} = s;
        {bg, vend, en, slave, pg} = f;
        repeat (2) @(negedge clock);
        acc(1'b0, 8'h79, 2'h2, w);
        acc(1'b0, 8'h78, 2'h1, {8'h00, w[7:0]});
        cmp({8'h00, w[7:0]}, {8'h00, crit});
        cmp(w, word);
    endtask

    task automatic mask(input logic m);
        mv = m;
        mw = 1'b1;
        @(negedge clock);
        mw = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    initial begin
        srst = 1'b1;
        {vs, io, ts, comms} = 32'h0;
        ins = 8'h00;
        {bg, vend, en, slave, pg, von, voff, vclr, mw, mv} = 10'h0;
        err_count = 0;
        checked = 0;
        repeat (16) @(negedge clock);
        cmp(16'h2001, word);
        srst = 1'b0;
        acc(1'b0, 8'h79, 2'h2, 16'h2841);
        mask(1'b0);
        cmp(16'h0000, {14'h0, lv_alert, png_alert});
        cmp(16'h0001, {15'h0, lv_flag});
        mask(1'b1);
        von = 1'b1;
        src(32'h00000000, 5'h05, 16'h0000);
        // outside bit 3 is replaced by the local flag
        ins = 8'h08;
        src(32'h00000000, 5'h05, 16'h0000);
        ins = 8'h80;
        src(32'h00000000, 5'h05, 16'h2000);
        ins = 8'h00;
        src(32'h80000000, 5'h05, 16'h8020);
        src(32'h80000000, 5'h07, 16'h0000);
        src(32'h40000000, 5'h05, 16'h8001);
        src(32'h24000000, 5'h05, 16'h8001);
        src(32'h1b000000, 5'h05, 16'h8001);
        src(32'h00800000, 5'h05, 16'h4010);
        src(32'h00200000, 5'h05, 16'h4001);
        src(32'h0000c000, 5'h05, 16'h0004);
        src(32'h00000081, 5'h05, 16'h0002);
        src(32'h00000000, 5'h15, 16'h1001);
        src(32'h00000000, 5'h0d, 16'h1001);
        src(32'h00000000, 5'h01, 16'h0040);
        src(32'h00000000, 5'h04, 16'h0800);
        cmp(16'h0000, {15'h0, png_alert});
        acc(1'b1, 8'h78, 2'h0, 16'h0000);
        acc(1'b1, 8'h79, 2'h0, 16'h0000);
        acc(1'b0, 8'h79, 2'h2, 16'h0800);
        acc(1'b0, 8'h7a, 2'h0, 16'h0000);
        mask(1'b0);
        cmp(16'h0001, {15'h0, png_alert});
        voff = 1'b1;
        @(negedge clock);
        voff = 1'b0;
        @(negedge clock);
        cmp(16'h0003, {14'h0, lv_flag, lv_alert});
        src(32'h00000000, 5'h05, 16'h2001);
        vclr = 1'b1;
        @(negedge clock);
        vclr = 1'b0;
        src(32'h00000000, 5'h05, 16'h0000);
        // second reset mid-run: power-up values come back
        srst = 1'b1;
        repeat (2) @(negedge clock);
        cmp(16'h2001, word);
        cmp(16'h0002, {14'h0, lv_flag, lv_alert});
        srst = 1'b0;
        src(32'h00000000, 5'h05, 16'h0000);
        finish_test();
    end
endmodule
